// [verilog/adcst_seq_trig_cfg.sv]
`timescale 1ns/1ps
module adcst_seq_trig_cfg #(
   parameter bit HAS_DED_TRIG = 1'b1
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [5:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdData,
   // conversion control
   input  wire logic        startConv,
   input  wire logic        multiChannelScan,
   input  wire logic [3:0]  startChannel,
   input  wire logic        resultJustifySelect,
   input  wire logic [11:0] convData,
   // trigger pins
   input  wire logic [9:0]  analogTrigPins,
   input  wire logic [3:0]  dedicatedTriggerInputs,
   // status
   output logic             busy,
   output logic             sampleActive,
   output logic             dischargeActive,
   output logic [3:0]       activeChannel,
   output logic [1:0]       resultResolutionField,
   output logic             extTrigger,
   output logic             seqAbort
);
   adcst_res_if res ();

   adcst_pkg::adcst_state_t state_r;
   logic [3:0]  wrap_r;
   logic [7:0]  trig_r;
   logic [3:0]  chan_r;
   logic [3:0]  cnt_r;
   logic        multi_r;
   logic [7:0]  ctlRd_r;
   logic        memSel_r;
   logic        extTrig_r;
   logic        abort_r;
   logic [9:0]  anMeta_r;
   logic [9:0]  anSync_r;
   logic [3:0]  dedMeta_r;
   logic [3:0]  dedSync_r;

   // register decode
   wire wrapSel   = regWr && (regAddr == adcst_pkg::OFS_WRAP);
   wire trigSel   = regWr && (regAddr == adcst_pkg::OFS_TRIG);
   wire ctlWrite  = wrapSel || trigSel;
   wire res8Wr    = regWr && (regAddr == adcst_pkg::OFS_RES8);
   wire res9Wr    = regWr && (regAddr == adcst_pkg::OFS_RES9);
   wire resRd     = regRd && ((regAddr == adcst_pkg::OFS_RES8) ||
                              (regAddr == adcst_pkg::OFS_RES9));
   wire rsvdRd    = regRd && (regAddr >= adcst_pkg::OFS_RSVD_LO) &&
                             (regAddr <= adcst_pkg::OFS_RSVD_HI);
   wire rsvdWr    = regWr && (regAddr >= adcst_pkg::OFS_RSVD_LO) &&
                             (regAddr <= adcst_pkg::OFS_RSVD_HI);

   // control fields
   wire       trigClass = trig_r[adcst_pkg::TRIG_CLASS_BIT];
   wire [1:0] resField  = trig_r[adcst_pkg::RES_MSB:adcst_pkg::RES_LSB];
   wire       disBit    = trig_r[adcst_pkg::DIS_BIT];
   wire [3:0] srcIdx    = trig_r[adcst_pkg::SRC_MSB:0];

   // wrap limit: zero code wraps after channel 0, codes above 9 act as 9
   wire [3:0] wrapLimit = (wrap_r > adcst_pkg::LAST_CHAN) ? adcst_pkg::LAST_CHAN
                                                          : wrap_r;

   // trigger source selection
   wire       classEff  = trigClass && HAS_DED_TRIG;
   wire [3:0] anIdx     = (srcIdx > adcst_pkg::LAST_CHAN) ? adcst_pkg::LAST_CHAN
                                                         : srcIdx;
   wire       dedValid  = srcIdx < adcst_pkg::DED_TRIG_N;
   wire       trigNxt   = classEff ? (dedValid && dedSync_r[srcIdx[1:0]])
                                   : anSync_r[anIdx];

   // sample and conversion lengths
   wire [3:0] sampleLen = adcst_pkg::SAMPLE_CYC +
                          (disBit ? adcst_pkg::DISCHARGE_CYC : 4'h0);
   wire [3:0] convLen   = (resField == adcst_pkg::RES_8)  ? adcst_pkg::CONV_CYC_8 :
                          (resField == adcst_pkg::RES_10) ? adcst_pkg::CONV_CYC_10 :
                                                            adcst_pkg::CONV_CYC_12;
   wire [3:0] firstChan = (startChannel > adcst_pkg::LAST_CHAN) ? adcst_pkg::LAST_CHAN
                                                                : startChannel;

   // sequence progress
   wire inIdle    = state_r == adcst_pkg::ST_IDLE;
   wire inSample  = state_r == adcst_pkg::ST_SAMPLE;
   wire inConvert = state_r == adcst_pkg::ST_CONVERT;
   wire convDone  = inConvert && (cnt_r == 4'h0) && !ctlWrite;
   wire scanMore  = multi_r && (chan_r != wrapLimit) && (chan_r < adcst_pkg::LAST_CHAN);

   // result justification by resolution
   wire [15:0] leftVal  = (resField == adcst_pkg::RES_8)  ? {convData[11:4], 8'h00} :
                          (resField == adcst_pkg::RES_10) ? {convData[11:2], 6'h00} :
                                                            {convData, 4'h0};
   wire [15:0] rightVal = (resField == adcst_pkg::RES_8)  ? {8'h00, convData[11:4]} :
                          (resField == adcst_pkg::RES_10) ? {6'h00, convData[11:2]} :
                                                            {4'h0, convData};
   wire resChan  = (chan_r == 4'h8) || (chan_r == adcst_pkg::LAST_CHAN);
   wire convWrite = convDone && resChan;

   // result store access
   assign res.wrEn   = convWrite || res8Wr || res9Wr;
   assign res.wrIdx  = convWrite ? chan_r[0] : res9Wr;
   assign res.wrData = convWrite ? (resultJustifySelect ? rightVal : leftVal)
                                 : regWrData;
   assign res.rdEn   = resRd;
   assign res.rdIdx  = regAddr[1];

   adcst_result_store u_store (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .res     (res.store)
   );

   // pin synchronisers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         anMeta_r  <= 10'h000;
         anSync_r  <= 10'h000;
         dedMeta_r <= 4'h0;
         dedSync_r <= 4'h0;
      end else begin
         anMeta_r  <= analogTrigPins;
         anSync_r  <= anMeta_r;
         dedMeta_r <= dedicatedTriggerInputs;
         dedSync_r <= dedMeta_r;
      end
   end

   // control registers, writable at any time
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wrap_r <= adcst_pkg::WRAP_RST;
         trig_r <= adcst_pkg::TRIG_RST;
      end else begin
         if (wrapSel) begin
            wrap_r <= regWrData[3:0];
         end
         if (trigSel) begin
            trig_r <= regWrData[7:0];
         end
      end
   end

   // read data, one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctlRd_r  <= 8'h00;
         memSel_r <= 1'b0;
      end else begin
         memSel_r <= resRd;
         if (regRd && (regAddr == adcst_pkg::OFS_WRAP)) begin
            ctlRd_r <= {4'h0, wrap_r};
         end else if (regRd && (regAddr == adcst_pkg::OFS_TRIG)) begin
            ctlRd_r <= trig_r;
         end else begin
            ctlRd_r <= 8'h00;
         end
      end
   end

   assign regRdData = memSel_r ? res.rdData : {8'h00, ctlRd_r};

   // conversion sequencer
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= adcst_pkg::ST_IDLE;
         chan_r  <= 4'h0;
         cnt_r   <= 4'h0;
         multi_r <= 1'b0;
      end else if (ctlWrite) begin
         state_r <= adcst_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
      end else begin
         unique case (state_r)
            adcst_pkg::ST_IDLE: begin
               if (startConv) begin
                  multi_r <= multiChannelScan;
                  chan_r  <= multiChannelScan ? 4'h0 : firstChan;
                  cnt_r   <= sampleLen - 4'h1;
                  state_r <= adcst_pkg::ST_SAMPLE;
               end
            end
            adcst_pkg::ST_SAMPLE: begin
               if (cnt_r == 4'h0) begin
                  cnt_r   <= convLen - 4'h1;
                  state_r <= adcst_pkg::ST_CONVERT;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            adcst_pkg::ST_CONVERT: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (scanMore) begin
                  chan_r  <= chan_r + 4'h1;
                  cnt_r   <= sampleLen - 4'h1;
                  state_r <= adcst_pkg::ST_SAMPLE;
               end else begin
                  state_r <= adcst_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // trigger output and abort indication
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         extTrig_r <= 1'b0;
         abort_r   <= 1'b0;
      end else begin
         extTrig_r <= trigNxt;
         abort_r   <= ctlWrite && !inIdle;
      end
   end

   // status outputs
   assign busy                  = !inIdle;
   assign sampleActive          = inSample;
   assign dischargeActive       = inSample && disBit &&
                                  (cnt_r >= adcst_pkg::SAMPLE_CYC);
   assign activeChannel         = chan_r;
   assign resultResolutionField = resField;
   assign extTrigger            = extTrig_r;
   assign seqAbort              = abort_r;

   // checks
   property p_abort;
      @(posedge ref_clk) disable iff (!rstn)
      ctlWrite |=> inIdle && !busy;
   endproperty
   a_abort: assert property (p_abort) else $error("control write did not abort");

   property p_wrap_bound;
      @(posedge ref_clk) disable iff (!rstn)
      (busy && multi_r) |-> (chan_r <= wrapLimit) && (wrapLimit <= 4'h9);
   endproperty
   a_wrap_bound: assert property (p_wrap_bound) else $error("scan passed wrap channel");

   property p_trig_rw;
      @(posedge ref_clk) disable iff (!rstn)
      (trigSel ##1 (regRd && regAddr == adcst_pkg::OFS_TRIG && !trigSel))
         |=> regRdData == {8'h00, $past(regWrData[7:0], 2)};
   endproperty
   a_trig_rw: assert property (p_trig_rw) else $error("trigger register readback wrong");

   property p_ded_trig;
      @(posedge ref_clk) disable iff (!rstn)
      (classEff && dedValid && !trigSel) |=> extTrigger == $past(dedSync_r[srcIdx[1:0]]);
   endproperty
   a_ded_trig: assert property (p_ded_trig) else $error("dedicated trigger not routed");

   property p_analog_trig;
      @(posedge ref_clk) disable iff (!rstn)
      (!classEff && !trigSel) |=> extTrigger == $past(anSync_r[anIdx]);
   endproperty
   a_analog_trig: assert property (p_analog_trig) else $error("analog trigger not routed");

   property p_rsvd_trig;
      @(posedge ref_clk) disable iff (!rstn)
      (classEff && srcIdx >= 4'h4) |=> !extTrigger;
   endproperty
   a_rsvd_trig: assert property (p_rsvd_trig) else $error("reserved trigger index fired");

   property p_conv_len;
      @(posedge ref_clk) disable iff (!rstn)
      (inSample && cnt_r == 4'h0 && !ctlWrite && resField == adcst_pkg::RES_8)
         |=> inConvert && cnt_r == 4'h7;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("8-bit conversion length wrong");

   property p_discharge;
      @(posedge ref_clk) disable iff (!rstn)
      (inIdle && startConv && !ctlWrite && disBit) |=> inSample && cnt_r == 4'h5;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge not added to sample");

   property p_res9;
      @(posedge ref_clk) disable iff (!rstn)
      ((res9Wr && !convWrite) ##1 (regRd && regAddr == adcst_pkg::OFS_RES9))
         |=> regRdData == $past(regWrData, 2);
   endproperty
   a_res9: assert property (p_res9) else $error("channel 9 result word lost");

   property p_rsvd_read;
      @(posedge ref_clk) disable iff (!rstn)
      rsvdRd |=> regRdData == 16'h0000;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved offset read nonzero");

   property p_rsvd_write;
      @(posedge ref_clk) disable iff (!rstn)
      rsvdWr |=> $stable(wrap_r) && $stable(trig_r);
   endproperty
   a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed control");

   property p_abort_flag;
      @(posedge ref_clk) disable iff (!rstn)
      (ctlWrite && busy) |=> seqAbort;
   endproperty
   a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");

   property p_wrap_stop;
      @(posedge ref_clk) disable iff (!rstn)
      (convDone && multi_r && chan_r == wrapLimit) |=> inIdle;
   endproperty
   a_wrap_stop: assert property (p_wrap_stop) else $error("scan did not stop at wrap");

   property p_sample_len;
      @(posedge ref_clk) disable iff (!rstn)
      (inIdle && startConv && !ctlWrite && !disBit) |=> inSample && cnt_r == 4'h3;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("plain sample length wrong");

   property p_conv_len10;
      @(posedge ref_clk) disable iff (!rstn)
      (inSample && cnt_r == 4'h0 && !ctlWrite && resField == adcst_pkg::RES_10)
         |=> inConvert && cnt_r == 4'h9;
   endproperty
   a_conv_len10: assert property (p_conv_len10) else $error("10-bit length wrong");

   property p_conv_len12;
      @(posedge ref_clk) disable iff (!rstn)
      (inSample && cnt_r == 4'h0 && !ctlWrite && resField == 2'h2)
         |=> inConvert && cnt_r == 4'hB;
   endproperty
   a_conv_len12: assert property (p_conv_len12) else $error("12-bit length wrong");

   property p_class_store;
      @(posedge ref_clk) disable iff (!rstn)
      trigSel |=> trigClass == $past(regWrData[adcst_pkg::TRIG_CLASS_BIT]);
   endproperty
   a_class_store: assert property (p_class_store) else $error("class bit not stored");
endmodule

// [verilog/adcst_pkg.sv]
package adcst_pkg;
   // register offsets
   localparam logic [5:0] OFS_WRAP    = 6'h00;
   localparam logic [5:0] OFS_TRIG    = 6'h01;
   localparam logic [5:0] OFS_RES8    = 6'h20;
   localparam logic [5:0] OFS_RES9    = 6'h22;
   localparam logic [5:0] OFS_RSVD_LO = 6'h24;
   localparam logic [5:0] OFS_RSVD_HI = 6'h2F;
   // trigger/resolution field positions
   localparam int TRIG_CLASS_BIT = 7;
   localparam int RES_MSB        = 6;
   localparam int RES_LSB        = 5;
   localparam int DIS_BIT        = 4;
   localparam int SRC_MSB        = 3;
   // reset values
   localparam logic [3:0] WRAP_RST = 4'hF;
   localparam logic [7:0] TRIG_RST = 8'h00;
   // channel limits and resolution codes
   localparam logic [3:0] LAST_CHAN   = 4'h9;
   localparam logic [3:0] DED_TRIG_N  = 4'h4;
   localparam logic [1:0] RES_8       = 2'h0;
   localparam logic [1:0] RES_10      = 2'h1;
   // timing in converter clock cycles
   localparam logic [3:0] SAMPLE_CYC    = 4'h4;
   localparam logic [3:0] DISCHARGE_CYC = 4'h2;
   localparam logic [3:0] CONV_CYC_8    = 4'h8;
   localparam logic [3:0] CONV_CYC_10   = 4'hA;
   localparam logic [3:0] CONV_CYC_12   = 4'hC;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcst_state_t;
endpackage

// [verilog/adcst_res_if.sv]
`timescale 1ns/1ps
interface adcst_res_if;
   logic        wrEn;
   logic        wrIdx;
   logic [15:0] wrData;
   logic        rdEn;
   logic        rdIdx;
   logic [15:0] rdData;
   modport ctrl  (output wrEn, wrIdx, wrData, rdEn, rdIdx, input rdData);
   modport store (input wrEn, wrIdx, wrData, rdEn, rdIdx, output rdData);
endinterface

// [verilog/adcst_result_store.sv]
`timescale 1ns/1ps
module adcst_result_store (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // result access
   adcst_res_if.store res
);
   logic [15:0] mem [0:1];
   logic [15:0] rdData_r;

   // word store for channels 8 and 9
   always_ff @(posedge ref_clk) begin
      if (res.wrEn) begin
         mem[res.wrIdx] <= res.wrData;
      end
   end

   // registered read port
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdData_r <= 16'h0000;
      end else if (res.rdEn) begin
         rdData_r <= mem[res.rdIdx];
      end
   end

   assign res.rdData = rdData_r;
endmodule

// [verification/adc_sequence_trigger_config_bench.sv]
`timescale 1ns/1ps
module adc_sequence_trigger_config_bench;
   // clock and reset
   logic        ref_clk;
   logic        rstn;
   // register port
   logic [5:0]  regAddr;
   logic [15:0] regWrData;
   logic        regWr;
   logic        regRd;
   logic [15:0] regRdData;
   // conversion control and trigger pins
   logic        startConv;
   logic        multiChannelScan;
   logic [3:0]  startChannel;
   logic        resultJustifySelect;
   logic [11:0] convData;
   logic [9:0]  analogTrigPins;
   logic [3:0]  dedicatedTriggerInputs;
   // status
   logic        busy;
   logic        sampleActive;
   logic        dischargeActive;
   logic [3:0]  activeChannel;
   logic [1:0]  resultResolutionField;
   logic        extTrigger;
   logic        seqAbort;
   // bench state
   int          errTotal;
   int          nCompared;
   int          seed;
   int          nb;
   int          ns;
   int          nd;
   logic [31:0] rnd;
   logic [15:0] rd;
   logic [15:0] expQ [$];
   logic        extTriggerNd;
   logic [15:0] rdNd;
   logic [7:0]  v;
   logic        dis;
   logic        expT;

   adcst_seq_trig_cfg dut_u (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .startConv(startConv), .multiChannelScan(multiChannelScan), .startChannel(startChannel),
      .resultJustifySelect(resultJustifySelect), .convData(convData),
      .analogTrigPins(analogTrigPins), .dedicatedTriggerInputs(dedicatedTriggerInputs),
      .busy(busy), .sampleActive(sampleActive), .dischargeActive(dischargeActive),
      .activeChannel(activeChannel), .resultResolutionField(resultResolutionField),
      .extTrigger(extTrigger), .seqAbort(seqAbort));

   // second copy without dedicated trigger inputs
   adcst_seq_trig_cfg #(.HAS_DED_TRIG(1'b0)) dutNoDed_u (.ref_clk(ref_clk), .rstn(rstn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(rdNd), .startConv(startConv), .multiChannelScan(multiChannelScan),
      .startChannel(startChannel), .resultJustifySelect(resultJustifySelect),
      .convData(convData), .analogTrigPins(analogTrigPins),
      .dedicatedTriggerInputs(dedicatedTriggerInputs), .busy(), .sampleActive(),
      .dischargeActive(), .activeChannel(), .resultResolutionField(),
      .extTrigger(extTriggerNd), .seqAbort());

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // comparison helpers, one per kind of result
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chkn(input int got, input int exp);
      nCompared++;
      if (got != exp) begin
         errTotal++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single-cycle register accesses
   task automatic regWrite(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic regRead(input logic [5:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic regWriteRead(input logic [5:0] a, input logic [15:0] wd,
                               output logic [15:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= wd;
      @(posedge ref_clk);
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask

   // start pulse, then count busy, sample and discharge cycles
   task automatic startPulse(input logic multi, input logic [3:0] ch);
      @(posedge ref_clk);
      rnd = $random(seed);
      startConv <= 1'b1;
      multiChannelScan <= multi;
      startChannel <= ch;
      convData <= rnd[11:0];
      resultJustifySelect <= rnd[12];
      @(posedge ref_clk);
      startConv <= 1'b0;
      #1;
   endtask
   task automatic runSeq(input logic multi, input logic [3:0] ch);
      startPulse(multi, ch);
      nb = 0;
      ns = 0;
      nd = 0;
      while (busy === 1'b1 && nb < 2000) begin
         nb++;
         ns += (sampleActive === 1'b1);
         nd += (dischargeActive === 1'b1);
         @(posedge ref_clk);
         #1;
      end
   endtask

   // bench model of result placement and conversion length
   function automatic logic [15:0] expWord(input logic [1:0] r, input logic rj,
                                           input logic [11:0] d);
      case (r)
         2'h0:    expWord = rj ? {8'h00, d[11:4]} : {d[11:4], 8'h00};
         2'h1:    expWord = rj ? {6'h00, d[11:2]} : {d[11:2], 6'h00};
         default: expWord = rj ? {4'h0, d} : {d, 4'h0};
      endcase
   endfunction
   function automatic int convCyc(input int r);
      convCyc = (r == 0) ? 8 : (r == 1) ? 10 : 12;
   endfunction

   // verdict and run end
   task automatic printVerdict;
      $display("compared %0d mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      errTotal++;
      printVerdict;
   end

   // main sequence
   initial begin
      seed = 26;
      {rstn, regAddr, regWrData, regWr, regRd, startConv, multiChannelScan} = '0;
      {startChannel, resultJustifySelect, convData, analogTrigPins} = '0;
      dedicatedTriggerInputs = 4'h0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      regRead(adcst_pkg::OFS_WRAP, rd);
      chk16(rd, {12'h000, adcst_pkg::WRAP_RST});
      regRead(adcst_pkg::OFS_TRIG, rd);
      chk16(rd, {8'h00, adcst_pkg::TRIG_RST});
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         regWriteRead(adcst_pkg::OFS_TRIG, {8'h00, v}, rd);
         chk16(rd, {8'h00, v});
         chk16(rdNd, {8'h00, v});
         chk16({14'h0000, resultResolutionField}, {14'h0000, v[6:5]});
      end
      $display("test trigger register access done");
      for (int a = 36; a <= 47; a++) begin
         regWriteRead(a[5:0], 16'($random(seed)), rd);
         chk16(rd, 16'h0000);
      end
      regRead(adcst_pkg::OFS_TRIG, rd);
      chk16(rd, {8'h00, v});
      rnd = $random(seed);
      regWriteRead(adcst_pkg::OFS_RES9, rnd[15:0], rd);
      chk16(rd, rnd[15:0]);
      $display("test reserved space and result word done");
      for (int r = 0; r < 4; r++) begin
         for (int ch = 8; ch < 10; ch++) begin
            dis = 1'($random(seed));
            regWrite(adcst_pkg::OFS_TRIG, {9'h000, r[1:0], dis, 4'h0});
            runSeq(1'b0, ch[3:0]);
            chkn(nb, (dis ? 6 : 4) + convCyc(r));
            chkn(ns, dis ? 6 : 4);
            chkn(nd, dis ? 2 : 0);
            expQ.push_back(expWord(r[1:0], resultJustifySelect, convData));
            regRead((ch == 8) ? adcst_pkg::OFS_RES8 : adcst_pkg::OFS_RES9, rd);
            chk16(rd, expQ.pop_front());
         end
      end
      $display("test single conversions done");
      regWrite(adcst_pkg::OFS_TRIG, 16'h0000);
      for (int w = 1; w < 16; w++) begin
         regWrite(adcst_pkg::OFS_WRAP, {12'h000, w[3:0]});
         regRead(adcst_pkg::OFS_WRAP, rd);
         chk16(rd, {12'h000, w[3:0]});
         runSeq(1'b1, 4'h0);
         chkn(nb, (((w > 9) ? 9 : w) + 1) * 12);
         chk16({12'h000, activeChannel}, {12'h000, ((w > 9) ? 4'h9 : w[3:0])});
      end
      $display("test scan wrap done");
      for (int k = 0; k < 2; k++) begin
         startPulse(1'b1, 4'h0);
         repeat (5) @(posedge ref_clk);
         regWrite(k[0] ? adcst_pkg::OFS_TRIG : adcst_pkg::OFS_WRAP, k[0] ? 16'h0 : 16'hF);
         chk1(seqAbort, 1'b1);
         chk1(busy, 1'b0);
         @(posedge ref_clk);
         #1 chk1(seqAbort, 1'b0);
      end
      $display("test abort done");
      for (int c = 0; c < 32; c++) begin
         regWrite(adcst_pkg::OFS_TRIG, {8'h00, c[4], 3'h0, c[3:0]});
         @(posedge ref_clk);
         rnd = $random(seed);
         analogTrigPins <= rnd[9:0];
         dedicatedTriggerInputs <= rnd[13:10];
         repeat (4) @(posedge ref_clk);
         #1;
         if (c[4]) expT = (c[3:0] < 4) ? dedicatedTriggerInputs[c[1:0]] : 1'b0;
         else expT = analogTrigPins[(c[3:0] > 9) ? 9 : c[3:0]];
         chk1(extTrigger, expT);
         chk1(extTriggerNd, analogTrigPins[(c[3:0] > 9) ? 9 : c[3:0]]);
      end
      $display("test trigger selection done");
      printVerdict;
   end
endmodule
